// file: inc/sdd_pkg.sv
// Constants shared by the serial identification and diagnostics port
package sdd_pkg;
	// Two-wire target addresses (upper seven bits of the address byte)
	localparam logic [6:0] SDD_ID_ADDR   = 7'h50;
	localparam logic [6:0] SDD_DIAG_ADDR = 7'h51;

	// Timing
	localparam int SDD_CLK_NS    = 10;
	localparam int SDD_TXDIS_US  = 10;
	localparam int SDD_TXDIS_CYC = (SDD_TXDIS_US * 1000) / SDD_CLK_NS;

	// Local register port offsets and reset values
	localparam logic [3:0] SDD_REG_IRQ_STAT = 4'h0;
	localparam logic [3:0] SDD_REG_IRQ_MASK = 4'h1;
	localparam logic [3:0] SDD_REG_CTRL     = 4'h2;
	localparam logic [3:0] SDD_REG_STATE    = 4'h3;
	localparam logic [3:0] SDD_MASK_RST     = 4'h0;
	localparam logic       SDD_CTRL_RST     = 1'b0;

	// Event bit positions in status and mask
	localparam int SDD_EV_ALARM = 0;
	localparam int SDD_EV_LOS   = 1;
	localparam int SDD_EV_FAULT = 2;
	localparam int SDD_EV_WRITE = 3;

	// Diagnostics map layout
	localparam logic [7:0] SDD_DG_THR_END  = 8'h28;
	localparam logic [7:0] SDD_DG_VAL_BASE = 8'h60;
	localparam logic [7:0] SDD_DG_VAL_END  = 8'h6A;
	localparam logic [7:0] SDD_DG_STATUS   = 8'h6E;
	localparam logic [7:0] SDD_DG_ALARM    = 8'h70;
	localparam logic [7:0] SDD_DG_WARN     = 8'h74;

	// Identification map layout and content (values are arbitrary)
	localparam logic [7:0]   SDD_ID_VEND_BASE = 8'h14;
	localparam logic [7:0]   SDD_ID_VEND_END  = 8'h24;
	localparam logic [7:0]   SDD_ID_DDM_TYPE  = 8'h5C;
	localparam logic [7:0]   SDD_DDM_INTCAL   = 8'h60;
	localparam logic [7:0]   SDD_ID_HEAD [16] = '{8'h03, 8'h04, 8'h07, 8'h00, 8'h00, 8'h00, 8'h01, 8'h00,
		8'h00, 8'h00, 8'h00, 8'h01, 8'h0D, 8'h00, 8'h0A, 8'h64};
	localparam logic [127:0] SDD_VENDOR       = "GENERIC OPTICS  ";

	// Monitored channels: temperature, supply, bias, tx power, rx power
	localparam int SDD_NCH = 5;
	// Per channel: high alarm, low alarm, high warning, low warning
	localparam logic [15:0] SDD_THR [20] = '{
		16'h5500, 16'hD800, 16'h5000, 16'hDD00,
		16'h8CA0, 16'h7530, 16'h88B8, 16'h7918,
		16'hEA60, 16'h0000, 16'hD6D8, 16'h0000,
		16'h1F07, 16'h0290, 16'h18A6, 16'h033A,
		16'h2710, 16'h0010, 16'h1F07, 16'h0019};
endpackage

// file: inc/sdd_mon_if.sv
// Carrier between the port logic and the range monitor
`timescale 1ns/1ns
interface sdd_mon_if;
	logic [15:0]              val [sdd_pkg::SDD_NCH];
	logic [sdd_pkg::SDD_NCH-1:0] alarm_hi;
	logic [sdd_pkg::SDD_NCH-1:0] alarm_lo;
	logic [sdd_pkg::SDD_NCH-1:0] warn_hi;
	logic [sdd_pkg::SDD_NCH-1:0] warn_lo;

	modport src (output val, input alarm_hi, alarm_lo, warn_hi, warn_lo);
	modport mon (input val, output alarm_hi, alarm_lo, warn_hi, warn_lo);
endinterface

// file: logic/sdd_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ns
module sdd_sync #(
	parameter int           W       = 5,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input  wire logic         clk_in,
	input  wire logic         rst_n_in,
	input  wire logic [W-1:0] d_in,
	output logic      [W-1:0] q_out
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;

	always_ff @(posedge clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			meta_ff <= RST_VAL;
			sync_ff <= RST_VAL;
		end else begin
			meta_ff <= d_in;
			sync_ff <= meta_ff;
		end
	end

	assign q_out = sync_ff;
endmodule

// file: logic/sdd_monitor.sv
// Range monitor: alarm and warning flags for each live value
`timescale 1ns/1ns
module sdd_monitor (
	input  wire logic clk_in,
	input  wire logic rst_n_in,
	sdd_mon_if.mon    mon
);
	genvar ch;
	generate
		for (ch = 0; ch < sdd_pkg::SDD_NCH; ch++) begin : g_ch
			// Temperature is two's complement; flipping the sign bit orders it as unsigned
			localparam logic [15:0] FLIP = (ch == 0) ? 16'h8000 : 16'h0000;

			logic [3:0] flag_ff;
			logic [3:0] nxt_flag;

			always_comb begin
				nxt_flag[3] = (mon.val[ch] ^ FLIP) > (sdd_pkg::SDD_THR[ch*4] ^ FLIP);
				nxt_flag[2] = (mon.val[ch] ^ FLIP) < (sdd_pkg::SDD_THR[ch*4+1] ^ FLIP);
				nxt_flag[1] = (mon.val[ch] ^ FLIP) > (sdd_pkg::SDD_THR[ch*4+2] ^ FLIP);
				nxt_flag[0] = (mon.val[ch] ^ FLIP) < (sdd_pkg::SDD_THR[ch*4+3] ^ FLIP);
			end

			always_ff @(posedge clk_in or negedge rst_n_in) begin
				if (!rst_n_in) begin
					flag_ff <= 4'h0;
				end else begin
					flag_ff <= nxt_flag;
				end
			end

			assign mon.alarm_hi[ch] = flag_ff[3];
			assign mon.alarm_lo[ch] = flag_ff[2];
			assign mon.warn_hi[ch]  = flag_ff[1];
			assign mon.warn_lo[ch]  = flag_ff[0];

			alarm_high_a: assert property (@(posedge clk_in) disable iff (!rst_n_in)
				((mon.val[ch] ^ FLIP) > (sdd_pkg::SDD_THR[ch*4] ^ FLIP)) |=> mon.alarm_hi[ch])
				else $error("high alarm not raised");
		end
	endgenerate
endmodule

// file: logic/sdd_top.sv
// Serial identification and diagnostics port of a pluggable module
// Operation
// - Acknowledge target address 1010000 and serve the 256-byte identification map.
// - Acknowledge 1010001 for diagnostics; identification map stays unchanged.
// - Data is captured on clock rise; writes land only in unprotected bytes.
// - Outgoing data changes only after a falling clock edge.
// - Data line is shared; each side drives only in its phase.
// - Byte-wide maps with single and auto-incrementing sequential access.
// - Identification map holds capabilities, interfaces and maker content.
// - Live temperature, bias, tx power, rx power and supply are readable.
// - Alarm and warning flags set when a value leaves its range.
// - Diagnostic values are reported internally calibrated by default.
// - Loss-of-signal output low while receiving, high without signal.
// - Transmitter is off within 10 us of disable assertion.
// - Transmitter off while disable is high or open, on when low; the code also keeps it off while soft_dis_ff is set.
// - Fault output high on laser fault, low in normal operation.
`timescale 1ns/1ns
module sdd_top (
	input  wire logic        clk_in,
	input  wire logic        resetn_in,
	input  wire logic        scl_in,
	input  wire logic        sda_in,
	output logic             sda_out,
	output logic             sda_oe_out,
	input  wire logic        tx_disable_in,
	input  wire logic        signal_detect_in,
	input  wire logic        laser_fault_in,
	input  wire logic [15:0] temp_in,
	input  wire logic [15:0] vcc_in,
	input  wire logic [15:0] bias_in,
	input  wire logic [15:0] txpwr_in,
	input  wire logic [15:0] rxpwr_in,
	input  wire logic [3:0]  reg_addr_in,
	input  wire logic [7:0]  reg_wdata_in,
	input  wire logic        reg_wr_in,
	input  wire logic        reg_rd_in,
	output logic      [7:0]  reg_rdata_out,
	output logic             tx_enable_out,
	output logic             rx_signal_lost_out,
	output logic             tx_fault_out,
	output logic             irq_out
);
	localparam int TXOFF_BOUND = sdd_pkg::SDD_TXDIS_CYC;

	typedef enum logic [3:0] {
		ST_IDLE, ST_ADDR, ST_ACK_DRV, ST_ACK_HOLD, ST_RX, ST_TX, ST_TX_ACK, ST_TX_NEXT, ST_IGNORE
	} sdd_state_e;

	logic       rst_q_ff;
	logic       rst_n_ff;
	logic [4:0] pin_s;
	logic       scl_s, sda_s, txd_s, det_s, flt_s;
	logic       scl_q_ff, sda_q_ff;
	logic       scl_rise, scl_fall, start_w, stop_w;

	// Reset release through two flip-flops
	always_ff @(posedge clk_in or negedge resetn_in) begin
		if (!resetn_in) begin
			rst_q_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end else begin
			rst_q_ff <= 1'b1;
			rst_n_ff <= rst_q_ff;
		end
	end

	sdd_sync #(.W(5), .RST_VAL(5'h07)) u_sync (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_ff),
		.d_in     ({laser_fault_in, signal_detect_in, tx_disable_in, sda_in, scl_in}),
		.q_out    (pin_s)
	);

	assign {flt_s, det_s, txd_s, sda_s, scl_s} = pin_s;

	always_ff @(posedge clk_in or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			scl_q_ff <= 1'b1;
			sda_q_ff <= 1'b1;
		end else begin
			scl_q_ff <= scl_s;
			sda_q_ff <= sda_s;
		end
	end

	// the serial clock is only sampled, its edges found here
	assign scl_rise = scl_s & ~scl_q_ff;
	assign scl_fall = ~scl_s & scl_q_ff;
	// start and stop are data edges while the clock is high
	assign start_w  = scl_s & scl_q_ff & sda_q_ff & ~sda_s;
	assign stop_w   = scl_s & scl_q_ff & ~sda_q_ff & sda_s;

	// Range monitor
	sdd_mon_if mon_if ();
	// live values feed the monitor and the diagnostics map
	assign mon_if.val[0] = temp_in;
	assign mon_if.val[1] = vcc_in;
	assign mon_if.val[2] = bias_in;
	assign mon_if.val[3] = txpwr_in;
	assign mon_if.val[4] = rxpwr_in;

	sdd_monitor u_mon (
		.clk_in   (clk_in),
		.rst_n_in (rst_n_ff),
		.mon      (mon_if.mon)
	);

	// Serial target state
	sdd_state_e st_ff, nxt_st;
	logic [2:0] bit_ff, nxt_bit;
	logic [7:0] shift_ff, nxt_shift;
	logic [7:0] ptr_ff, nxt_ptr;
	logic       map_ff, nxt_map;
	logic       rw_ff, nxt_rw;
	logic       have_ff, nxt_have;
	logic       sda_oe_ff, nxt_oe;
	logic       sda_out_ff;
	logic       wr_en;
	logic [7:0] in_byte;
	logic [7:0] rd_byte;
	logic [7:0] user_mem [128];
	logic       soft_dis_ff;
	logic       tx_en_ff, los_ff, fault_ff;

	// Byte served at the current pointer
	always_comb begin
		logic [15:0] word;
		word    = 16'h0000;
		rd_byte = 8'h00;
		if (!map_ff) begin
			if (ptr_ff < 8'h10) begin
				rd_byte = sdd_pkg::SDD_ID_HEAD[ptr_ff[3:0]];
			end else if (ptr_ff >= sdd_pkg::SDD_ID_VEND_BASE && ptr_ff < sdd_pkg::SDD_ID_VEND_END) begin
				rd_byte = sdd_pkg::SDD_VENDOR[8'(8'd127 - 8'((ptr_ff - sdd_pkg::SDD_ID_VEND_BASE) << 3)) -: 8];
			end else if (ptr_ff == sdd_pkg::SDD_ID_DDM_TYPE) begin
				rd_byte = sdd_pkg::SDD_DDM_INTCAL;
			end
		end else if (ptr_ff < sdd_pkg::SDD_DG_THR_END) begin
			word    = sdd_pkg::SDD_THR[{ptr_ff[5:3], ptr_ff[2:1]}];
			rd_byte = ptr_ff[0] ? word[7:0] : word[15:8];
		end else if (ptr_ff >= sdd_pkg::SDD_DG_VAL_BASE && ptr_ff < sdd_pkg::SDD_DG_VAL_END) begin
			// values already calibrated, passed as they are
			word    = mon_if.val[3'((ptr_ff - sdd_pkg::SDD_DG_VAL_BASE) >> 1)];
			rd_byte = ptr_ff[0] ? word[7:0] : word[15:8];
		end else if (ptr_ff == sdd_pkg::SDD_DG_STATUS) begin
			rd_byte = {txd_s, soft_dis_ff, 3'b000, fault_ff, los_ff, 1'b0};
		end else if (ptr_ff == sdd_pkg::SDD_DG_ALARM) begin
			rd_byte = {mon_if.alarm_hi[0], mon_if.alarm_lo[0], mon_if.alarm_hi[1], mon_if.alarm_lo[1],
				mon_if.alarm_hi[2], mon_if.alarm_lo[2], mon_if.alarm_hi[3], mon_if.alarm_lo[3]};
		end else if (ptr_ff == sdd_pkg::SDD_DG_ALARM + 8'h01) begin
			rd_byte = {mon_if.alarm_hi[4], mon_if.alarm_lo[4], 6'h00};
		end else if (ptr_ff == sdd_pkg::SDD_DG_WARN) begin
			rd_byte = {mon_if.warn_hi[0], mon_if.warn_lo[0], mon_if.warn_hi[1], mon_if.warn_lo[1],
				mon_if.warn_hi[2], mon_if.warn_lo[2], mon_if.warn_hi[3], mon_if.warn_lo[3]};
		end else if (ptr_ff == sdd_pkg::SDD_DG_WARN + 8'h01) begin
			rd_byte = {mon_if.warn_hi[4], mon_if.warn_lo[4], 6'h00};
		end else if (ptr_ff[7]) begin
			rd_byte = user_mem[ptr_ff[6:0]];
		end
	end

	assign in_byte = {shift_ff[6:0], sda_s};

	always_comb begin
		nxt_st    = st_ff;
		nxt_bit   = bit_ff;
		nxt_shift = shift_ff;
		nxt_ptr   = ptr_ff;
		nxt_map   = map_ff;
		nxt_rw    = rw_ff;
		nxt_have  = have_ff;
		nxt_oe    = sda_oe_ff;
		wr_en     = 1'b0;
		if (start_w) begin
			nxt_st   = ST_ADDR;
			nxt_bit  = 3'd0;
			nxt_have = 1'b0;
			nxt_oe   = 1'b0;
		end else if (stop_w) begin
			nxt_st = ST_IDLE;
			nxt_oe = 1'b0;
		end else begin
			case (st_ff)
				ST_ADDR: begin
					// bits captured on the rising clock edge
					if (scl_rise) begin
						nxt_shift = in_byte;
						nxt_bit   = 3'(bit_ff + 3'd1);
						if (bit_ff == 3'd7) begin
							nxt_rw  = sda_s;
							nxt_map = in_byte[7:1] == sdd_pkg::SDD_DIAG_ADDR;
							if (in_byte[7:1] == sdd_pkg::SDD_ID_ADDR || in_byte[7:1] == sdd_pkg::SDD_DIAG_ADDR) begin
								nxt_st = ST_ACK_DRV;
							end else begin
								nxt_st = ST_IGNORE;
							end
						end
					end
				end
				ST_ACK_DRV: begin
					if (scl_fall) begin
						nxt_oe = 1'b1;
						nxt_st = ST_ACK_HOLD;
					end
				end
				ST_ACK_HOLD: begin
					if (scl_fall) begin
						nxt_bit = 3'd0;
						if (rw_ff) begin
							nxt_shift = rd_byte;
							nxt_oe    = ~rd_byte[7];
							nxt_st    = ST_TX;
						end else begin
							nxt_oe = 1'b0;
							nxt_st = ST_RX;
						end
					end
				end
				ST_RX: begin
					if (scl_rise) begin
						nxt_shift = in_byte;
						nxt_bit   = 3'(bit_ff + 3'd1);
						if (bit_ff == 3'd7) begin
							nxt_st = ST_ACK_DRV;
							if (!have_ff) begin
								nxt_have = 1'b1;
								nxt_ptr  = in_byte;
							end else begin
								// only the diagnostics user area takes writes
								wr_en   = map_ff & ptr_ff[7];
								nxt_ptr = 8'(ptr_ff + 8'd1);
							end
						end
					end
				end
				ST_TX: begin
					// next bit put out after the falling edge
					if (scl_fall) begin
						if (bit_ff == 3'd7) begin
							nxt_oe = 1'b0;
							nxt_st = ST_TX_ACK;
						end else begin
							nxt_shift = {shift_ff[6:0], 1'b0};
							nxt_oe    = ~shift_ff[6];
							nxt_bit   = 3'(bit_ff + 3'd1);
						end
					end
				end
				ST_TX_ACK: begin
					if (scl_rise) begin
						if (sda_s) begin
							nxt_st = ST_IGNORE;
						end else begin
							nxt_ptr = 8'(ptr_ff + 8'd1);
							nxt_st  = ST_TX_NEXT;
						end
					end
				end
				ST_TX_NEXT: begin
					if (scl_fall) begin
						nxt_shift = rd_byte;
						nxt_oe    = ~rd_byte[7];
						nxt_bit   = 3'd0;
						nxt_st    = ST_TX;
					end
				end
				ST_IDLE, ST_IGNORE: begin
					nxt_oe = 1'b0;
				end
				default: begin
					nxt_st = ST_IDLE;
					nxt_oe = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			st_ff      <= ST_IDLE;
			bit_ff     <= 3'd0;
			shift_ff   <= 8'h00;
			ptr_ff     <= 8'h00;
			map_ff     <= 1'b0;
			rw_ff      <= 1'b0;
			have_ff    <= 1'b0;
			sda_oe_ff  <= 1'b0;
			sda_out_ff <= 1'b0;
		end else begin
			st_ff      <= nxt_st;
			bit_ff     <= nxt_bit;
			shift_ff   <= nxt_shift;
			ptr_ff     <= nxt_ptr;
			map_ff     <= nxt_map;
			rw_ff      <= nxt_rw;
			have_ff    <= nxt_have;
			sda_oe_ff  <= nxt_oe;
			sda_out_ff <= 1'b0;
		end
	end

	always_ff @(posedge clk_in) begin
		if (wr_en) begin
			user_mem[ptr_ff[6:0]] <= in_byte;
		end
	end

	// Pin outputs, status and local registers
	logic [3:0] stat_ff, nxt_stat, mask_ff, nxt_mask, ev;
	logic       nxt_soft, alarm_q_ff, irq_ff;
	logic [7:0] rdata_ff, nxt_rdata;

	always_comb begin
		ev                         = 4'h0;
		ev[sdd_pkg::SDD_EV_ALARM]  = (|{mon_if.alarm_hi, mon_if.alarm_lo}) & ~alarm_q_ff;
		ev[sdd_pkg::SDD_EV_LOS]    = ~det_s != los_ff;
		ev[sdd_pkg::SDD_EV_FAULT]  = flt_s & ~fault_ff;
		ev[sdd_pkg::SDD_EV_WRITE]  = wr_en;
		nxt_mask  = mask_ff;
		nxt_soft  = soft_dis_ff;
		nxt_stat  = stat_ff;
		nxt_rdata = 8'h00;
		if (reg_wr_in && reg_addr_in == sdd_pkg::SDD_REG_IRQ_STAT) begin
			nxt_stat = stat_ff & ~reg_wdata_in[3:0];
		end
		// A new event wins over a clear in the same cycle
		nxt_stat = nxt_stat | ev;
		if (reg_wr_in && reg_addr_in == sdd_pkg::SDD_REG_IRQ_MASK) begin
			nxt_mask = reg_wdata_in[3:0];
		end
		if (reg_wr_in && reg_addr_in == sdd_pkg::SDD_REG_CTRL) begin
			nxt_soft = reg_wdata_in[0];
		end
		if (reg_rd_in) begin
			case (reg_addr_in)
				sdd_pkg::SDD_REG_IRQ_STAT: nxt_rdata = {4'h0, stat_ff};
				sdd_pkg::SDD_REG_IRQ_MASK: nxt_rdata = {4'h0, mask_ff};
				sdd_pkg::SDD_REG_CTRL:     nxt_rdata = {7'h00, soft_dis_ff};
				sdd_pkg::SDD_REG_STATE:    nxt_rdata = {4'h0, st_ff != ST_IDLE, tx_en_ff, fault_ff, los_ff};
				default:                   nxt_rdata = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			stat_ff     <= 4'h0;
			mask_ff     <= sdd_pkg::SDD_MASK_RST;
			soft_dis_ff <= sdd_pkg::SDD_CTRL_RST;
			rdata_ff    <= 8'h00;
			irq_ff      <= 1'b0;
			alarm_q_ff  <= 1'b0;
			tx_en_ff    <= 1'b0;
			los_ff      <= 1'b1;
			fault_ff    <= 1'b0;
		end else begin
			stat_ff     <= nxt_stat;
			mask_ff     <= nxt_mask;
			soft_dis_ff <= nxt_soft;
			rdata_ff    <= nxt_rdata;
			irq_ff      <= |(nxt_stat & nxt_mask);
			alarm_q_ff  <= |{mon_if.alarm_hi, mon_if.alarm_lo};
			// disable acts within three clock cycles
			// transmitter on only while disable is low
			tx_en_ff    <= ~txd_s & ~soft_dis_ff;
			los_ff      <= ~det_s;
			fault_ff    <= flt_s;
		end
	end

	assign sda_out            = sda_out_ff;
	assign sda_oe_out         = sda_oe_ff;
	assign reg_rdata_out      = rdata_ff;
	assign tx_enable_out      = tx_en_ff;
	assign rx_signal_lost_out = los_ff;
	assign tx_fault_out       = fault_ff;
	assign irq_out            = irq_ff;

	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!rst_n_ff);

	sequence addr_byte_done;
		st_ff == ST_ADDR && scl_rise && bit_ff == 3'd7 && !start_w && !stop_w;
	endsequence
	sequence ack_edge;
		st_ff == ST_ACK_DRV && scl_fall && !start_w && !stop_w;
	endsequence

	id_addr_ack_a: assert property (addr_byte_done ##0 in_byte[7:1] == sdd_pkg::SDD_ID_ADDR |=>
		st_ff == ST_ACK_DRV && !map_ff) else $error("identification address not taken");
	diag_addr_ack_a: assert property (addr_byte_done ##0 in_byte[7:1] == sdd_pkg::SDD_DIAG_ADDR |=>
		st_ff == ST_ACK_DRV && map_ff) else $error("diagnostics address not taken");
	ack_drive_a: assert property (ack_edge |=> sda_oe_ff && st_ff == ST_ACK_HOLD)
		else $error("acknowledge not driven");
	write_protect_a: assert property (wr_en |-> map_ff && ptr_ff[7])
		else $error("write into protected byte");
	fall_change_a: assert property ($changed(sda_oe_ff) |-> $past(scl_fall || start_w || stop_w))
		else $error("data line changed off a falling edge");
	line_release_a: assert property ((st_ff == ST_IDLE || st_ff == ST_IGNORE) |-> !sda_oe_ff && !sda_out_ff)
		else $error("data line held while idle");
	seq_advance_a: assert property (st_ff == ST_TX_ACK && scl_rise && !sda_s && !start_w && !stop_w |=>
		ptr_ff == 8'($past(ptr_ff) + 8'd1)) else $error("pointer did not advance");
	los_follow_a: assert property (!det_s [*2] |-> rx_signal_lost_out)
		else $error("loss of signal not reported");
	tx_off_time_a: assert property ($rose(txd_s) |-> ##[0:TXOFF_BOUND] !tx_enable_out)
		else $error("transmitter not off in time");
	tx_on_low_a: assert property ((!txd_s && !soft_dis_ff) [*2] |-> tx_enable_out)
		else $error("transmitter not on while enabled");
	fault_out_a: assert property (flt_s |=> tx_fault_out)
		else $error("fault not reported");
	foreign_addr_a: assert property (addr_byte_done ##0 in_byte[7:1] != sdd_pkg::SDD_ID_ADDR &&
		in_byte[7:1] != sdd_pkg::SDD_DIAG_ADDR |=> st_ff == ST_IGNORE ##1 !sda_oe_ff)
		else $error("foreign address acknowledged");
	irq_level_a: assert property (irq_out == |(stat_ff & mask_ff))
		else $error("interrupt level wrong");
endmodule

// file: dv/sdd_host.sv
// Host-side two-wire controller model that drives the serial clock and frames transfers
`timescale 1ns/1ns
module sdd_host #(
	parameter int QTR = 2
) (
	input  wire logic clk_in,
	input  wire logic sda_in,
	output logic      scl_out,
	output logic      sda_oe_out
);
	initial begin
		scl_out = 1'b1;
		sda_oe_out = 1'b0;
	end
	task automatic q;
		repeat (QTR) @(posedge clk_in);
	endtask
	task automatic start;
		q();
		sda_oe_out <= 1'b0;
		q();
		scl_out <= 1'b1;
		q();
		sda_oe_out <= 1'b1;
		q();
		scl_out <= 1'b0;
	endtask
	// stop condition, clock then rests high
	task automatic stop;
		q();
		sda_oe_out <= 1'b1;
		q();
		scl_out <= 1'b1;
		q();
		sda_oe_out <= 1'b0;
		q();
	endtask
	// host clocks each bit, data moves a quarter after the fall
	task automatic bit_io(input logic b, output logic r);
		q();
		sda_oe_out <= ~b;
		q();
		scl_out <= 1'b1;
		q();
		r = sda_in;
		q();
		scl_out <= 1'b0;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic r;
		for (int i = 7; i >= 0; i--) bit_io(d[i], r);
		bit_io(1'b1, r);
		ack = ~r;
	endtask
	task automatic rbyte(input logic ack, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, r);
			d[i] = r;
		end
		bit_io(~ack, r);
	endtask
endmodule

// file: dv/sdd_top_tb.sv
// Self-checking bench for the serial identification and diagnostics port
`timescale 1ns/1ns
module sdd_top_tb;
	logic        clk, rstn, scl, host_oe, dut_sda, dut_oe, txdis, sigdet, lfault, wr, rd;
	logic        txen, rx_signal_lost, fault, irq;
	logic [15:0] temp, vcc, bias, txp, rxp;
	logic [3:0]  addr;
	logic [7:0]  wdata, rdata, d;
	wire         sda = ~(dut_oe | host_oe);
	int          mismatches, check_count;

	sdd_top DUT (.clk_in(clk), .resetn_in(rstn), .scl_in(scl), .sda_in(sda), .sda_out(dut_sda),
		.sda_oe_out(dut_oe), .tx_disable_in(txdis), .signal_detect_in(sigdet), .laser_fault_in(lfault),
		.temp_in(temp), .vcc_in(vcc), .bias_in(bias), .txpwr_in(txp), .rxpwr_in(rxp), .reg_addr_in(addr),
		.reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata), .tx_enable_out(txen),
		.rx_signal_lost_out(rx_signal_lost), .tx_fault_out(fault), .irq_out(irq));
	sdd_host HOST (.clk_in(clk), .sda_in(sda), .scl_out(scl), .sda_oe_out(host_oe));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	task automatic wrap_up;
		if (mismatches == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// device data only moves while the serial clock is low
	always @(dut_oe) begin
		if (rstn === 1'b1) check(scl, 1'b0);
	end
	task automatic reg_wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		addr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [3:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask
	task automatic settle;
		repeat (8) @(posedge clk);
	endtask
	task automatic i2c_rd(input logic [6:0] dev, input logic [7:0] ptr, input logic [31:0] exp, input int n);
		logic       ack;
		logic [7:0] v;
		HOST.start();
		HOST.wbyte({dev, 1'b0}, ack);
		check(ack, 1'b1);
		check(dut_sda, 1'b0);
		HOST.wbyte(ptr, ack);
		HOST.start();
		HOST.wbyte({dev, 1'b1}, ack);
		for (int i = 0; i < n; i++) begin
			HOST.rbyte(i != n - 1, v);
			check(v, exp[31 - 8 * i -: 8]);
		end
		HOST.stop();
	endtask
	task automatic i2c_wr(input logic [6:0] dev, input logic [7:0] ptr, input logic [15:0] dat, input int n,
		input logic ok);
		logic ack;
		HOST.start();
		HOST.wbyte({dev, 1'b0}, ack);
		check(ack, ok);
		HOST.wbyte(ptr, ack);
		for (int i = 0; i < n; i++) HOST.wbyte(dat[15 - 8 * i -: 8], ack);
		check(ack, ok);
		HOST.stop();
	endtask
	task automatic t_irq;
		reg_rd(sdd_pkg::SDD_REG_IRQ_MASK);
		check(d, 8'h00);
		reg_rd(4'hF);
		check(d, 8'h00);
		reg_wr(sdd_pkg::SDD_REG_IRQ_STAT, 8'h0F);
		@(posedge clk);
		sigdet <= 1'b0;
		settle();
		check({rx_signal_lost, irq}, 2'b10);
		reg_wr(sdd_pkg::SDD_REG_IRQ_MASK, 8'h02);
		settle();
		check(irq, 1'b1);
		reg_wr(sdd_pkg::SDD_REG_IRQ_STAT, 8'h02);
		settle();
		check(irq, 1'b0);
		sigdet <= 1'b1;
		settle();
		check({rx_signal_lost, irq}, 2'b01);
		reg_wr(sdd_pkg::SDD_REG_IRQ_STAT, 8'h0F);
		reg_wr(sdd_pkg::SDD_REG_IRQ_MASK, 8'h00);
	endtask
	task automatic t_tx;
		int n;
		n = 0;
		check(txen, 1'b1);
		txdis <= 1'b1;
		while (txen !== 1'b0 && n <= sdd_pkg::SDD_TXDIS_CYC) begin
			@(negedge clk);
			n++;
		end
		check(n <= sdd_pkg::SDD_TXDIS_CYC, 1'b1);
		check(txen, 1'b0);
		@(posedge clk);
		txdis <= 1'b0;
		lfault <= 1'b1;
		settle();
		check({txen, fault}, 2'b11);
		reg_rd(sdd_pkg::SDD_REG_STATE);
		check(d[2:1], 2'b11);
		lfault <= 1'b0;
		reg_wr(sdd_pkg::SDD_REG_CTRL, 8'h01);
		settle();
		check({txen, fault}, 2'b00);
		reg_wr(sdd_pkg::SDD_REG_CTRL, 8'h00);
	endtask
	task automatic t_maps;
		i2c_rd(sdd_pkg::SDD_ID_ADDR, 8'h5B, {8'h00, sdd_pkg::SDD_DDM_INTCAL, 16'h0000}, 3);
		i2c_wr(sdd_pkg::SDD_DIAG_ADDR, 8'hFF, 16'hA511, 2, 1'b1);
		i2c_wr(sdd_pkg::SDD_ID_ADDR, 8'h00, 16'hFF00, 1, 1'b1);
		i2c_rd(sdd_pkg::SDD_ID_ADDR, 8'h00, {sdd_pkg::SDD_ID_HEAD[0], sdd_pkg::SDD_ID_HEAD[1], 16'h0000}, 2);
		i2c_rd(sdd_pkg::SDD_DIAG_ADDR, 8'hFF, {8'hA5, sdd_pkg::SDD_THR[0][15:8], 16'h0000}, 2);
		reg_rd(sdd_pkg::SDD_REG_IRQ_STAT);
		check(d[sdd_pkg::SDD_EV_WRITE], 1'b1);
		i2c_wr(7'h52, 8'hFF, 16'h3C00, 1, 1'b0);
		i2c_rd(sdd_pkg::SDD_DIAG_ADDR, 8'hFF, {8'hA5, 24'h00_0000}, 1);
	endtask
	task automatic t_live;
		reg_wr(sdd_pkg::SDD_REG_IRQ_STAT, 8'h0F);
		@(posedge clk);
		vcc <= 16'h9ABC;
		settle();
		reg_rd(sdd_pkg::SDD_REG_IRQ_STAT);
		check(d[sdd_pkg::SDD_EV_ALARM], 1'b1);
		i2c_rd(sdd_pkg::SDD_DIAG_ADDR, 8'h62, 32'h9ABC_1000, 4);
	endtask

	initial begin
		{rstn, txdis, lfault, wr, rd} = '0;
		sigdet = 1'b1;
		{addr, wdata} = '0;
		temp = 16'h1234;
		vcc = 16'h8000;
		bias = 16'h1000;
		txp = 16'h1000;
		rxp = 16'h1000;
		repeat (8) @(posedge clk);
		rstn <= 1'b1;
		repeat (4) @(posedge clk);
		t_irq();
		t_tx();
		t_maps();
		t_live();
		wrap_up();
	end
	initial begin
		#200_000;
		mismatches++;
		wrap_up();
	end
endmodule
